// *** logic/cfg_slot_pkg.sv ***
/*
 * Shared types and constants for the configuration slot store:
 * slot codes, the live settings record, factory defaults and timing.
 * Assumes a single 25 MHz clock domain.
 */
`default_nettype none

package cfg_slot_pkg;

   // ---------------------------------------------------------------
   // Slot codes
   // ---------------------------------------------------------------
   typedef logic [1:0] slot_t;
   localparam slot_t SLOT_FACTORY = 2'h0;
   localparam slot_t SLOT_USER1   = 2'h1;
   localparam slot_t SLOT_USER2   = 2'h2;

   // ---------------------------------------------------------------
   // Live settings record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] frame_rate;
      logic [7:0]  image_format;
      logic [15:0] offset_x;
      logic [15:0] offset_y;
      logic [15:0] width;
      logic [15:0] height;
      logic [3:0]  video_mode;
      logic [3:0]  video_format;
      logic [3:0]  trigger_mode;
      logic [15:0] trigger_delay;
      logic [31:0] imaging;
      logic [15:0] gpio_modes;
      logic [7:0]  pixel_coding;
      logic [15:0] packet_size;
      logic [15:0] packet_delay;
      logic [7:0]  ctrl_channel_cfg;
      logic [15:0] heartbeat;
   } settings_t;

   // Factory defaults, held in logic so they can never be overwritten
   localparam settings_t FACTORY_SETTINGS = '{
      frame_rate:       16'h001E,
      image_format:     8'h00,
      offset_x:         16'h0000,
      offset_y:         16'h0000,
      width:            16'h0780,
      height:           16'h0438,
      video_mode:       4'h0,
      video_format:     4'h0,
      trigger_mode:     4'h0,
      trigger_delay:    16'h0000,
      imaging:          32'h0000_0000,
      gpio_modes:       16'h0000,
      pixel_coding:     8'h00,
      packet_size:      16'h05DC,
      packet_delay:     16'h0190,
      ctrl_channel_cfg: 8'h00,
      heartbeat:        16'h0BB8
   };

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ         = 25_000_000;
   localparam int BLANK_MS       = 100;
   localparam int BLANK_CYCLES   = BLANK_MS * (CLK_HZ / 1000);
   localparam int BLANK_CNT_W    = 22;

   // ---------------------------------------------------------------
   // Controller states (Gray along boot -> blank -> run)
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_BOOT  = 2'h0,
      ST_BLANK = 2'h1,
      ST_RUN   = 2'h3
   } ctl_state_t;

   typedef struct packed {
      logic src_ext;
      logic seen;
      logic reboot;
   } pwr_state_t;

endpackage : cfg_slot_pkg

`default_nettype wire

// *** logic/power_source_monitor.sv ***
/*
 * Power source selection and reboot request.
 * Assumes presence inputs synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module power_source_monitor
   import cfg_slot_pkg::*;
(
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ext_power_present,
   input  wire logic poe_power_present,
   output logic      source_ext,
   output logic      reboot_pulse
);

   pwr_state_t q;
   pwr_state_t d;
   logic       want_ext;

   always_comb begin
      d        = q;
      want_ext = ext_power_present;
      d.reboot = 1'b0;
      if (ext_power_present || poe_power_present) begin
         d.seen    = 1'b1;
         d.src_ext = want_ext;
         if (q.seen && (q.src_ext != want_ext)) begin
            d.reboot = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign source_ext   = q.src_ext;
   assign reboot_pulse = q.reboot;

endmodule : power_source_monitor

`default_nettype wire

// *** logic/user_config_set_store.sv ***
/*
 * Configuration slot store: factory slot plus two custom slots in
 * non-volatile storage, boot-time restore, image blanking after power-up
 * and reboot on power source change.
 * Assumes all inputs synchronous to clk; resetn models power-up.
 * Non-volatile contents survive resetn and are cleared only by nv_erase.
 */
`timescale 1ns/1ps
`default_nettype none

module user_config_set_store
   import cfg_slot_pkg::*;
#(
   parameter int BLANK_CNT = BLANK_CYCLES
)(
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire slot_t     config_slot_select,
   input  wire logic      config_slot_restore_cmd,
   input  wire logic      config_slot_store_cmd,
   input  wire slot_t     startup_config_slot,
   input  wire logic      startup_slot_wr,
   input  wire logic      reinit_cmd,
   input  wire logic      live_wr,
   input  wire settings_t live_settings_in,
   input  wire logic      nv_erase,
   input  wire logic      ext_power_present,
   input  wire logic      poe_power_present,
   output settings_t      live_settings,
   output slot_t          active_config_slot,
   output logic           image_output_enable,
   output logic           power_source_ext,
   output logic           init_done
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      ctl_state_t             st;
      settings_t              live;
      slot_t                  active;
      logic [BLANK_CNT_W-1:0] cnt;
      logic                   img_en;
      logic                   done;
      logic                   src_ext;
   } ctl_t;

   localparam logic [BLANK_CNT_W-1:0] BLANK_LAST = BLANK_CNT_W'(BLANK_CNT - 1);

   ctl_t      q;
   ctl_t      d;
   settings_t nv_slot [1:2];   // Custom slots, no reset
   slot_t     nv_boot_q;       // Slot loaded at initialisation
   logic      src_ext;
   logic      reboot;
   logic      sel_ok;
   settings_t sel_data;
   settings_t boot_data;

   power_source_monitor u_pwr (
      .clk               (clk),
      .resetn            (resetn),
      .ext_power_present (ext_power_present),
      .poe_power_present (poe_power_present),
      .source_ext        (src_ext),
      .reboot_pulse      (reboot)
   );

   // ---------------------------------------------------------------
   // Slot read mux
   // ---------------------------------------------------------------
   function automatic settings_t slot_read(input slot_t s, input settings_t u1,
                                           input settings_t u2);
      settings_t r;
      r = FACTORY_SETTINGS;
      if (s == SLOT_USER1) begin
         r = u1;
      end else if (s == SLOT_USER2) begin
         r = u2;
      end
      return r;
   endfunction : slot_read

   always_comb begin
      sel_ok    = (config_slot_select == SLOT_FACTORY) ||
                  (config_slot_select == SLOT_USER1)   ||
                  (config_slot_select == SLOT_USER2);
      sel_data  = slot_read(config_slot_select, nv_slot[1], nv_slot[2]);
      boot_data = slot_read(nv_boot_q, nv_slot[1], nv_slot[2]);
   end

   // ---------------------------------------------------------------
   // Controller
   // ---------------------------------------------------------------
   always_comb begin
      d         = q;
      d.src_ext = src_ext;
      unique case (q.st)
         ST_BOOT: begin
            d.live   = boot_data;
            d.active = nv_boot_q;
            d.done   = 1'b1;
            d.img_en = 1'b0;
            d.cnt    = '0;
            d.st     = ST_BLANK;
         end
         ST_BLANK: begin
            d.img_en = 1'b0;
            if (q.cnt == BLANK_LAST) begin
               d.img_en = 1'b1;
               d.st     = ST_RUN;
            end else begin
               d.cnt = q.cnt + 1'b1;
            end
         end
         ST_RUN: begin
            if (live_wr) begin
               d.live = live_settings_in;
            end
            if (config_slot_restore_cmd && sel_ok) begin
               d.live   = sel_data;
               d.active = config_slot_select;
            end
            if (reinit_cmd) begin
               d.st   = ST_BOOT;
               d.done = 1'b0;
            end
         end
         default: begin
            d.st = ST_BOOT;
         end
      endcase
      if (reboot) begin
         d        = '0;
         d.st     = ST_BOOT;
         d.src_ext = src_ext;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Non-volatile slots
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (nv_erase) begin
         nv_slot[1] <= FACTORY_SETTINGS;
         nv_slot[2] <= FACTORY_SETTINGS;
         nv_boot_q  <= SLOT_FACTORY;
      end else if (resetn && q.st == ST_RUN) begin
         if (config_slot_store_cmd && sel_ok) begin
            if (config_slot_select == SLOT_USER1) begin
               nv_slot[1] <= q.live;
            end else if (config_slot_select == SLOT_USER2) begin
               nv_slot[2] <= q.live;
            end
            nv_boot_q <= config_slot_select;
         end else if (startup_slot_wr && startup_config_slot != 2'h3) begin
            nv_boot_q <= startup_config_slot;
         end
      end
   end

   assign live_settings       = q.live;
   assign active_config_slot  = q.active;
   assign image_output_enable = q.img_en;
   assign power_source_ext    = q.src_ext;
   assign init_done           = q.done;

endmodule : user_config_set_store

`default_nettype wire

// *** testbench/user_config_set_store_properties.sv ***
/* Port checker for user_config_set_store, bound to every instance.
   Assumes one clock and the BLANK_CNT of the bound instance. */
`timescale 1ns/1ps
`default_nettype none
module cfg_store_checker
   import cfg_slot_pkg::*;
#(parameter int BLANK_CNT = 16)(
   input wire logic      clk,
   input wire logic      resetn,
   input wire slot_t     config_slot_select,
   input wire logic      config_slot_restore_cmd,
   input wire logic      reinit_cmd,
   input wire logic      live_wr,
   input wire settings_t live_settings_in,
   input wire logic      ext_power_present,
   input wire logic      poe_power_present,
   input wire settings_t live_settings,
   input wire slot_t     active_config_slot,
   input wire logic      image_output_enable,
   input wire logic      power_source_ext,
   input wire logic      init_done
);
   // -----------------------------
   // Blanked cycle count
   // -----------------------------
   logic [31:0] low_q;
   logic        cmd_ok;
   always_ff @(posedge clk) begin
      if (!resetn || image_output_enable) begin
         low_q <= 32'h0000_0000;
      end else begin
         low_q <= low_q + 32'h0000_0001;
      end
   end
   assign cmd_ok = image_output_enable && init_done && config_slot_restore_cmd &&
                   config_slot_select != 2'h3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // -----------------------------
   // Properties
   // -----------------------------
   property p_restore; cmd_ok |=> active_config_slot == $past(config_slot_select); endproperty
   a_restore: assert property (p_restore) else $error("restore slot wrong");
   property p_factory;
      cmd_ok && config_slot_select == SLOT_FACTORY |=> live_settings == FACTORY_SETTINGS;
   endproperty
   a_factory: assert property (p_factory) else $error("factory data wrong");
   property p_live;
      image_output_enable && init_done && live_wr && !config_slot_restore_cmd && !reinit_cmd
         |=> live_settings == $past(live_settings_in);
   endproperty
   a_live: assert property (p_live) else $error("live write lost");
   property p_hold;
      init_done && !image_output_enable && $stable(power_source_ext)
         |=> $stable(active_config_slot) && $stable(live_settings);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved while blanked");
   property p_range; active_config_slot != 2'h3; endproperty
   a_range: assert property (p_range) else $error("slot code invalid");
   property p_init; $rose(resetn) |-> ##[1:3] init_done; endproperty
   a_init: assert property (p_init) else $error("boot load late");
   property p_blank_min; $rose(image_output_enable) |-> low_q >= BLANK_CNT - 1; endproperty
   a_blank_min: assert property (p_blank_min) else $error("blanking short");
   property p_blank_max; !image_output_enable |-> low_q <= BLANK_CNT + 4; endproperty
   a_blank_max: assert property (p_blank_max) else $error("blanking long");
   property p_pref;
      $stable({ext_power_present, poe_power_present}) [*8] ##0
         (ext_power_present || poe_power_present) |-> power_source_ext == ext_power_present;
   endproperty
   a_pref: assert property (p_pref) else $error("power source wrong");
   property p_reboot;
      image_output_enable && poe_power_present && $rose(ext_power_present) |-> ##[1:4] !init_done;
   endproperty
   a_reboot: assert property (p_reboot) else $error("no reboot");
   c_restore: cover property (cmd_ok);
   c_reinit: cover property (image_output_enable && reinit_cmd);
   c_live: cover property (image_output_enable && live_wr);
endmodule : cfg_store_checker

bind user_config_set_store cfg_store_checker #(.BLANK_CNT(BLANK_CNT)) i_chk (.*);
`default_nettype wire

// *** testbench/user_config_set_store_tb.sv ***
/* Bench for user_config_set_store: store, restore, boot, power change.
   Assumes a short blanking count set through BLANK_CNT. */
`timescale 1ns/1ps
`default_nettype none
module user_config_set_store_tb
   import cfg_slot_pkg::*;
;
   localparam int        BC = 16;
   localparam settings_t SA = {4'h1, {7{32'h1111_A001}}};
   localparam settings_t SB = {4'h2, {7{32'h2222_B002}}};
   localparam settings_t SC = {4'h3, {7{32'h3333_C003}}};
   logic      clk, resetn, config_slot_restore_cmd, config_slot_store_cmd, startup_slot_wr;
   logic      reinit_cmd, live_wr, nv_erase, ext_power_present, poe_power_present;
   logic      image_output_enable, power_source_ext, init_done;
   slot_t     config_slot_select, startup_config_slot, active_config_slot;
   settings_t live_settings_in, live_settings;
   int        n_fail, samples_checked;
   int        n_wait;
   user_config_set_store #(.BLANK_CNT(BC)) i_dut (
      .clk                     (clk),
      .resetn                  (resetn),
      .config_slot_select      (config_slot_select),
      .config_slot_restore_cmd (config_slot_restore_cmd),
      .config_slot_store_cmd   (config_slot_store_cmd),
      .startup_config_slot     (startup_config_slot),
      .startup_slot_wr         (startup_slot_wr),
      .reinit_cmd              (reinit_cmd),
      .live_wr                 (live_wr),
      .live_settings_in        (live_settings_in),
      .nv_erase                (nv_erase),
      .ext_power_present       (ext_power_present),
      .poe_power_present       (poe_power_present),
      .live_settings           (live_settings),
      .active_config_slot      (active_config_slot),
      .image_output_enable     (image_output_enable),
      .power_source_ext        (power_source_ext),
      .init_done               (init_done)
   );
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input settings_t seen, input settings_t exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cycles
   // Kind: 0 restore, 1 store, 2 startup write, 3 reinit, 4 live write
   task automatic cmd(input int kind, input slot_t sel, input settings_t v);
      @(posedge clk);
      config_slot_select <= sel;
      startup_config_slot <= sel;
      live_settings_in <= v;
      config_slot_restore_cmd <= (kind == 0);
      config_slot_store_cmd <= (kind == 1);
      startup_slot_wr <= (kind == 2);
      reinit_cmd <= (kind == 3);
      live_wr <= (kind == 4);
      @(posedge clk);
      {config_slot_restore_cmd, config_slot_store_cmd, startup_slot_wr} <= 3'h0;
      {reinit_cmd, live_wr} <= 2'h0;
      cycles(1);
   endtask : cmd
   task automatic wait_run(output int n);
      n = 0;
      while (image_output_enable !== 1'b1) begin
         if (n == 300) begin
            n_fail++;
            complete_run();
         end
         cycles(1);
         n++;
      end
   endtask : wait_run
   task automatic power_up(input settings_t exp_live, input slot_t exp_slot);
      int n;
      @(posedge clk);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      cycles(1);
      check("enable", image_output_enable, 1'b0);
      cmd(0, SLOT_USER1, SC);
      wait_run(n);
      check("blank", n + 4 >= BC, 1'b1);
      check("live", live_settings, exp_live);
      check("slot", active_config_slot, exp_slot);
   endtask : power_up
   initial begin
      {resetn, config_slot_restore_cmd, config_slot_store_cmd, startup_slot_wr} = 4'h0;
      {reinit_cmd, live_wr, ext_power_present} = 3'h0;
      poe_power_present = 1'b1;
      nv_erase = 1'b1;
      config_slot_select = SLOT_FACTORY;
      startup_config_slot = SLOT_FACTORY;
      live_settings_in = SA;
      n_fail = 0;
      samples_checked = 0;
      @(posedge clk);
      nv_erase <= 1'b0;
      power_up(FACTORY_SETTINGS, SLOT_FACTORY);
      cmd(4, SLOT_FACTORY, SA);
      check("live", live_settings, SA);
      cmd(1, SLOT_USER1, SA);
      cmd(4, SLOT_FACTORY, SB);
      cmd(1, SLOT_USER2, SB);
      cmd(4, SLOT_FACTORY, SC);
      cmd(0, SLOT_USER1, SC);
      check("live", live_settings, SA);
      check("slot", active_config_slot, SLOT_USER1);
      cmd(0, SLOT_USER2, SC);
      check("live", live_settings, SB);
      check("slot", active_config_slot, SLOT_USER2);
      cmd(0, SLOT_FACTORY, SC);
      check("live", live_settings, FACTORY_SETTINGS);
      cmd(0, 2'h3, SC);
      check("slot", active_config_slot, SLOT_FACTORY);
      cmd(4, SLOT_FACTORY, SC);
      power_up(SB, SLOT_USER2);
      cmd(1, SLOT_FACTORY, SB);
      cmd(0, SLOT_FACTORY, SB);
      check("live", live_settings, FACTORY_SETTINGS);
      power_up(FACTORY_SETTINGS, SLOT_FACTORY);
      cmd(2, SLOT_USER1, SC);
      cmd(3, SLOT_FACTORY, SC);
      cycles(3);
      check("enable", image_output_enable, 1'b0);
      wait_run(n_wait);
      check("live", live_settings, SA);
      check("slot", active_config_slot, SLOT_USER1);
      cmd(4, SLOT_FACTORY, SC);
      @(posedge clk);
      ext_power_present <= 1'b1;
      for (int i = 0; i < 10 && init_done === 1'b1; i++) begin
         cycles(1);
      end
      check("reboot", init_done, 1'b0);
      cycles(3);
      wait_run(n_wait);
      check("source", power_source_ext, 1'b1);
      check("live", live_settings, SA);
      complete_run();
   end
endmodule : user_config_set_store_tb
`default_nettype wire
